// ### ppt_consts.svh
`ifndef PPT_CONSTS_SVH
`define PPT_CONSTS_SVH

// Register byte offsets on the APB
`define PPT_ADDR_W 12
`define PPT_OFF_CTRL 12'h000
`define PPT_OFF_START_TIME 12'h004
`define PPT_OFF_START_DATE 12'h008
`define PPT_OFF_CYCLE 12'h00c
`define PPT_OFF_STATUS 12'h010

// Field positions
`define PPT_MODE_LSB 0
`define PPT_SEC_LSB 0
`define PPT_MIN_LSB 8
`define PPT_HOUR_LSB 16
`define PPT_DAY_LSB 0
`define PPT_WDAY_LSB 8
`define PPT_MONTH_LSB 16
`define PPT_ST_STATE_LSB 0
`define PPT_ST_HOLD_BIT 4
`define PPT_ST_PULSE_BIT 5
`define PPT_ST_CNT_LSB 16

// Field widths
`define PPT_FIELD_W 6
`define PPT_WDAY_W 3
`define PPT_MONTH_W 4
`define PPT_CNT_W 16

// Ranges
`define PPT_MAX_HOUR 6'd23
`define PPT_MAX_MINSEC 6'd59
`define PPT_MAX_MDAY 6'd31
`define PPT_MIN_MDAY 6'd1
`define PPT_MIN_WDAY 3'd1
`define PPT_MAX_WDAY 3'd7
`define PPT_MIN_MONTH 4'd1
`define PPT_MAX_MONTH 4'd12

// Seconds arithmetic for the interval
`define PPT_SECS_W 17
`define PPT_SEC_PER_MIN 17'd60
`define PPT_SEC_PER_HOUR 17'd3600

// Reset values
`define PPT_RST_FIELD 6'd0
`define PPT_RST_DAY 6'd1
`define PPT_RST_WDAY 3'd1
`define PPT_RST_MONTH 4'd1

`endif

// ### ppt_interval.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppt_consts.svh"

module ppt_interval #(
  parameter int CNT_W = `PPT_SECS_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic run,
  input wire logic sec_tick,
  input wire logic [CNT_W-1:0] interval_s,
  output logic expire
);

  logic [CNT_W-1:0] elapsed_reg;
  logic [CNT_W-1:0] elapsed_next;

  assign elapsed_next = elapsed_reg + CNT_W'(1);
  // Zero interval behaves as one second, so the count never runs away
  assign expire = run && sec_tick && !load &&
                  (elapsed_next >= interval_s);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_reg <= '0;
    end else if (load) begin
      elapsed_reg <= '0;
    end else if (run && sec_tick) begin
      elapsed_reg <= expire ? '0 : elapsed_next;
    end
  end

  a_expire_reload: assert property (@(posedge pclk) disable iff (!presetn)
    expire |=> elapsed_reg == '0)
    else $error("interval did not reload after expiry");

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    run && sec_tick && !load && !expire |=>
    elapsed_reg == $past(elapsed_reg) + CNT_W'(1))
    else $error("interval count did not advance by one second");

endmodule

`default_nettype wire

// ### ppt_pkg.sv
package ppt_pkg;

  typedef enum logic [2:0] {
    PPT_MODE_MONTHLY,
    PPT_MODE_WEEKLY,
    PPT_MODE_DAILY,
    PPT_MODE_TIME_CYCLE,
    PPT_MODE_RESET_CYCLE
  } ppt_mode_t;

  typedef enum logic [1:0] {
    PPT_ST_STOP,
    PPT_ST_ARMED,
    PPT_ST_RUN
  } ppt_state_t;

endpackage

// ### ppt_rtc_model.sv
`timescale 1ns/1ps
`default_nettype none

module ppt_rtc_model #(
  parameter int SCAN_DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ld,
  input wire logic adv,
  input wire logic [2:0] ld_wday,
  input wire logic [4:0] ld_mday,
  input wire logic [4:0] ld_mdays,
  input wire logic [4:0] ld_hour,
  input wire logic [5:0] ld_min,
  input wire logic [5:0] ld_sec,
  output logic scan_tick,
  output logic [3:0] rtc_month,
  output logic [4:0] rtc_mday,
  output logic [4:0] rtc_month_days,
  output logic [2:0] rtc_wday,
  output logic [4:0] rtc_hour,
  output logic [5:0] rtc_min,
  output logic [5:0] rtc_sec
);
  logic [7:0] div_reg;

  // Scan strobe: one cycle wide, every SCAN_DIV cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
      scan_tick <= 1'b0;
    end else begin
      div_reg <= (div_reg == 8'(SCAN_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
      scan_tick <= (div_reg == 8'(SCAN_DIV - 1));
    end
  end

  // No hour carry: scenarios stay inside one hour
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_month <= 4'h1;
      rtc_mday <= 5'h01;
      rtc_month_days <= 5'h1f;
      rtc_wday <= 3'h1;
      rtc_hour <= 5'h00;
      rtc_min <= 6'h00;
      rtc_sec <= 6'h00;
    end else if (ld) begin
      rtc_wday <= ld_wday;
      rtc_mday <= ld_mday;
      rtc_month_days <= ld_mdays;
      rtc_hour <= ld_hour;
      rtc_min <= ld_min;
      rtc_sec <= ld_sec;
    end else if (adv) begin
      if (rtc_sec == 6'h3b) begin
        rtc_sec <= 6'h00;
        rtc_min <= rtc_min + 6'h01;
      end else begin
        rtc_sec <= rtc_sec + 6'h01;
      end
    end
  end
endmodule

`default_nettype wire

// ### ppt_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppt_consts.svh"

module ppt_timer
  import ppt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PPT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scan_tick,
  input wire logic hold_in,
  input wire logic [3:0] rtc_month,
  input wire logic [4:0] rtc_mday,
  input wire logic [4:0] rtc_month_days,
  input wire logic [2:0] rtc_wday,
  input wire logic [4:0] rtc_hour,
  input wire logic [5:0] rtc_min,
  input wire logic [5:0] rtc_sec,
  output logic pulse_out
);

  localparam int FW = `PPT_FIELD_W;

  function automatic logic [FW-1:0] clamp_hi(input logic [FW-1:0] v,
                                             input logic [FW-1:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic [`PPT_SECS_W-1:0] to_seconds(
      input logic [FW-1:0] h, input logic [FW-1:0] m, input logic [FW-1:0] s);
    logic [`PPT_SECS_W-1:0] hs;
    logic [`PPT_SECS_W-1:0] ms;
    hs = `PPT_SECS_W'(h) * `PPT_SEC_PER_HOUR;
    ms = `PPT_SECS_W'(m) * `PPT_SEC_PER_MIN;
    return hs + ms + `PPT_SECS_W'(s);
  endfunction

  ppt_mode_t mode_reg;
  ppt_state_t state_reg;
  logic [FW-1:0] st_sec_reg;
  logic [FW-1:0] st_min_reg;
  logic [FW-1:0] st_hour_reg;
  logic [FW-1:0] st_day_reg;
  logic [`PPT_WDAY_W-1:0] st_wday_reg;
  logic [`PPT_MONTH_W-1:0] st_month_reg;
  logic [FW-1:0] cy_sec_reg;
  logic [FW-1:0] cy_min_reg;
  logic [FW-1:0] cy_hour_reg;
  logic hold_prev_reg;
  logic match_prev_reg;
  logic [5:0] last_sec_reg;
  logic pulse_out_reg;
  logic [`PPT_CNT_W-1:0] pulse_cnt_reg;
  logic [31:0] prdata_reg;

  // APB decode
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic addr_hit;
  logic ctrl_wr;
  logic [31:0] rd_mux;

  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign apb_wr = apb_access && pwrite && addr_hit;
  assign ctrl_wr = apb_wr && (paddr == `PPT_OFF_CTRL);

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `PPT_OFF_CTRL:
        rd_mux[`PPT_MODE_LSB +: 3] = mode_reg;
      `PPT_OFF_START_TIME: begin
        rd_mux[`PPT_SEC_LSB +: FW] = st_sec_reg;
        rd_mux[`PPT_MIN_LSB +: FW] = st_min_reg;
        rd_mux[`PPT_HOUR_LSB +: FW] = st_hour_reg;
      end
      `PPT_OFF_START_DATE: begin
        rd_mux[`PPT_DAY_LSB +: FW] = st_day_reg;
        rd_mux[`PPT_WDAY_LSB +: `PPT_WDAY_W] = st_wday_reg;
        rd_mux[`PPT_MONTH_LSB +: `PPT_MONTH_W] = st_month_reg;
      end
      `PPT_OFF_CYCLE: begin
        rd_mux[`PPT_SEC_LSB +: FW] = cy_sec_reg;
        rd_mux[`PPT_MIN_LSB +: FW] = cy_min_reg;
        rd_mux[`PPT_HOUR_LSB +: FW] = cy_hour_reg;
      end
      `PPT_OFF_STATUS: begin
        rd_mux[`PPT_ST_STATE_LSB +: 2] = state_reg;
        rd_mux[`PPT_ST_HOLD_BIT] = hold_prev_reg;
        rd_mux[`PPT_ST_PULSE_BIT] = pulse_out_reg;
        rd_mux[`PPT_ST_CNT_LSB +: `PPT_CNT_W] = pulse_cnt_reg;
      end
      default:
        addr_hit = 1'b0;
    endcase
  end

  // Read data captured in setup so prdata comes from a flop, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_access && !addr_hit;

  // Mode register; unused codes keep the output quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= PPT_MODE_MONTHLY;
    end else if (ctrl_wr) begin
      mode_reg <= ppt_mode_t'(pwdata[`PPT_MODE_LSB +: 3]);
    end
  end

  // Configuration fields, clamped into range on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_sec_reg <= `PPT_RST_FIELD;
      st_min_reg <= `PPT_RST_FIELD;
      st_hour_reg <= `PPT_RST_FIELD;
    end else if (apb_wr && paddr == `PPT_OFF_START_TIME) begin
      st_sec_reg <= clamp_hi(pwdata[`PPT_SEC_LSB +: FW],
                             `PPT_MAX_MINSEC);
      st_min_reg <= clamp_hi(pwdata[`PPT_MIN_LSB +: FW], `PPT_MAX_MINSEC);
      st_hour_reg <= clamp_hi(pwdata[`PPT_HOUR_LSB +: FW], `PPT_MAX_HOUR);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_day_reg <= `PPT_RST_DAY;
      st_wday_reg <= `PPT_RST_WDAY;
      st_month_reg <= `PPT_RST_MONTH;
    end else if (apb_wr && paddr == `PPT_OFF_START_DATE) begin
      // Days above the month maximum collapse to it
      if (pwdata[`PPT_DAY_LSB +: FW] < `PPT_MIN_MDAY) begin
        st_day_reg <= `PPT_MIN_MDAY;
      end else begin
        st_day_reg <= clamp_hi(pwdata[`PPT_DAY_LSB +: FW],
                               `PPT_MAX_MDAY);
      end
      if (pwdata[`PPT_WDAY_LSB +: `PPT_WDAY_W] < `PPT_MIN_WDAY) begin
        st_wday_reg <= `PPT_MIN_WDAY;
      end else begin
        st_wday_reg <= pwdata[`PPT_WDAY_LSB +: `PPT_WDAY_W];
      end
      if (pwdata[`PPT_MONTH_LSB +: `PPT_MONTH_W] < `PPT_MIN_MONTH) begin
        st_month_reg <= `PPT_MIN_MONTH;
      end else if (pwdata[`PPT_MONTH_LSB +: `PPT_MONTH_W] >
                   `PPT_MAX_MONTH) begin
        st_month_reg <= `PPT_MAX_MONTH;
      end else begin
        st_month_reg <= pwdata[`PPT_MONTH_LSB +: `PPT_MONTH_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cy_sec_reg <= `PPT_RST_FIELD;
      cy_min_reg <= `PPT_RST_FIELD;
      cy_hour_reg <= `PPT_RST_FIELD;
    end else if (apb_wr && paddr == `PPT_OFF_CYCLE) begin
      cy_sec_reg <= clamp_hi(pwdata[`PPT_SEC_LSB +: FW],
                             `PPT_MAX_MINSEC);
      cy_min_reg <= clamp_hi(pwdata[`PPT_MIN_LSB +: FW], `PPT_MAX_MINSEC);
      cy_hour_reg <= clamp_hi(pwdata[`PPT_HOUR_LSB +: FW], `PPT_MAX_HOUR);
    end
  end

  // Schedule matching against the clock inputs
  logic tod_hit;
  logic [FW-1:0] fire_day;
  logic sched_hit;
  logic match_rise;
  logic hold_fall;
  logic sec_tick;
  logic is_calendar;
  logic is_cycle;

  assign tod_hit = ({1'b0, rtc_hour} == st_hour_reg) &&
                   (rtc_min == st_min_reg) && (rtc_sec == st_sec_reg);
  // Short months fire on their last day
  assign fire_day = (st_day_reg > {1'b0, rtc_month_days}) ?
                    {1'b0, rtc_month_days} : st_day_reg;
  assign is_calendar = (mode_reg == PPT_MODE_MONTHLY) ||
                       (mode_reg == PPT_MODE_WEEKLY) ||
                       (mode_reg == PPT_MODE_DAILY);
  assign is_cycle = (mode_reg == PPT_MODE_TIME_CYCLE) ||
                    (mode_reg == PPT_MODE_RESET_CYCLE);

  always_comb begin
    case (mode_reg)
      PPT_MODE_MONTHLY:
        sched_hit = tod_hit && ({1'b0, rtc_mday} == fire_day);
      PPT_MODE_WEEKLY:
        sched_hit = tod_hit && (rtc_wday == st_wday_reg);
      PPT_MODE_DAILY:
        sched_hit = tod_hit;
      PPT_MODE_TIME_CYCLE:
        sched_hit = tod_hit;
      default:
        sched_hit = 1'b0;
    endcase
  end

  // The clock sits on the match for many scans; only its first one counts
  assign match_rise = sched_hit && !match_prev_reg;
  assign hold_fall = hold_prev_reg && !hold_in;
  // Seconds are seen as changes of the clock's second field per scan
  assign sec_tick = scan_tick && (rtc_sec != last_sec_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_reg <= 1'b0;
      hold_prev_reg <= 1'b0;
      last_sec_reg <= 6'h00;
    end else if (scan_tick) begin
      match_prev_reg <= sched_hit;
      hold_prev_reg <= hold_in;
      last_sec_reg <= rtc_sec;
    end
  end

  logic start_fire;
  logic rc_fire;
  logic cyc_fire;
  logic cal_fire;
  logic fire;
  logic iv_load;
  logic iv_expire;

  assign start_fire = (mode_reg == PPT_MODE_TIME_CYCLE) &&
                      (state_reg != PPT_ST_RUN) && match_rise;
  assign rc_fire = (mode_reg == PPT_MODE_RESET_CYCLE) && hold_fall;
  assign cyc_fire = is_cycle && (state_reg == PPT_ST_RUN) && iv_expire;
  assign cal_fire = is_calendar && match_rise;
  assign fire = scan_tick && !hold_in && !ctrl_wr &&
                (start_fire || rc_fire || cyc_fire || cal_fire);
  assign iv_load = scan_tick && !hold_in && (start_fire || rc_fire);

  ppt_interval #(
    .CNT_W(`PPT_SECS_W)
  ) u_interval (
    .pclk(pclk),
    .presetn(presetn),
    .load(iv_load),
    .run(state_reg == PPT_ST_RUN && !hold_in),
    .sec_tick(sec_tick),
    .interval_s(to_seconds(cy_hour_reg, cy_min_reg, cy_sec_reg)),
    .expire(iv_expire)
  );

  // Sequencer for the two cycle schedules; a mode write restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PPT_ST_STOP;
    end else if (ctrl_wr) begin
      state_reg <= PPT_ST_STOP;
    end else if (scan_tick) begin
      if (hold_in) begin
        state_reg <= PPT_ST_STOP;
      end else begin
        case (mode_reg)
          PPT_MODE_TIME_CYCLE: begin
            if (state_reg == PPT_ST_RUN) begin
              state_reg <= PPT_ST_RUN;
            end else if (match_rise) begin
              state_reg <= PPT_ST_RUN;
            end else begin
              state_reg <= PPT_ST_ARMED;
            end
          end
          PPT_MODE_RESET_CYCLE: begin
            if (hold_fall) begin
              state_reg <= PPT_ST_RUN;
            end
          end
          default:
            state_reg <= PPT_ST_STOP;
        endcase
      end
    end
  end

  // Output changes only on the scan strobe, so it lasts one scan cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_out_reg <= 1'b0;
    end else if (scan_tick) begin
      pulse_out_reg <= fire;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_reg <= '0;
    end else if (fire) begin
      pulse_cnt_reg <= pulse_cnt_reg + `PPT_CNT_W'(1);
    end
  end

  assign pulse_out = pulse_out_reg;

  a_pulse_on_scan: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(pulse_out) |-> $past(scan_tick))
    else $error("output changed without a scan strobe");

  a_no_cause_low: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && !fire |=> !pulse_out)
    else $error("output high without a trigger");

  a_hold_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && hold_in |=> !pulse_out)
    else $error("pulse seen while hold was high");

  a_calendar_fire: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && !hold_in && !ctrl_wr && is_calendar && sched_hit &&
    !match_prev_reg |=> pulse_out)
    else $error("calendar match did not pulse");

  a_weekly_gate: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && mode_reg == PPT_MODE_WEEKLY && rtc_wday != st_wday_reg
    |=> !pulse_out)
    else $error("weekly pulse on the wrong weekday");

  a_daily_once: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && mode_reg == PPT_MODE_DAILY && match_prev_reg
    |=> !pulse_out)
    else $error("daily pulse repeated within the matching second");

  a_short_month: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && !hold_in && !ctrl_wr && mode_reg == PPT_MODE_MONTHLY &&
    tod_hit && !match_prev_reg && rtc_mday == rtc_month_days &&
    st_day_reg > {1'b0, rtc_month_days} |=> pulse_out)
    else $error("short month did not fire on its last day");

  a_cycle_stop: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && hold_in |=> state_reg == PPT_ST_STOP)
    else $error("hold did not stop the cycle");

  a_rc_start: assert property (@(posedge pclk) disable iff (!presetn)
    scan_tick && !ctrl_wr && mode_reg == PPT_MODE_RESET_CYCLE && hold_fall
    |=> pulse_out && state_reg == PPT_ST_RUN)
    else $error("falling hold did not pulse and start the cycle");

  a_run_persists: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == PPT_ST_RUN && !hold_in && !ctrl_wr
    |=> state_reg == PPT_ST_RUN)
    else $error("running cycle stopped without hold");

  a_ranges_held: assert property (@(posedge pclk) disable iff (!presetn)
    st_hour_reg <= `PPT_MAX_HOUR && cy_hour_reg <= `PPT_MAX_HOUR &&
    cy_min_reg <= `PPT_MAX_MINSEC && st_sec_reg <= `PPT_MAX_MINSEC)
    else $error("stored time field out of range");

endmodule

`default_nettype wire

// ### ppt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppt_consts.svh"

module ppt_timer_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic scan_tick, hold_in, pulse_out, ld, adv;
  logic pulse_q = 1'b0;
  logic [3:0] rtc_month;
  logic [4:0] rtc_mday, rtc_month_days, rtc_hour, ld_mday, ld_mdays, ld_hour;
  logic [2:0] rtc_wday, ld_wday;
  logic [5:0] rtc_min, rtc_sec, ld_min, ld_sec;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int checked = 0;
  int n_pulse = 0;
  int mark = 0;
  int width = 0;

  ppt_timer u_ppt_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_tick(scan_tick), .hold_in(hold_in), .rtc_month(rtc_month),
    .rtc_mday(rtc_mday), .rtc_month_days(rtc_month_days),
    .rtc_wday(rtc_wday), .rtc_hour(rtc_hour), .rtc_min(rtc_min),
    .rtc_sec(rtc_sec), .pulse_out(pulse_out));

  ppt_rtc_model #(.SCAN_DIV(4)) u_ppt_rtc_model (.pclk(pclk),
    .presetn(presetn), .ld(ld), .adv(adv), .ld_wday(ld_wday),
    .ld_mday(ld_mday), .ld_mdays(ld_mdays), .ld_hour(ld_hour),
    .ld_min(ld_min), .ld_sec(ld_sec), .scan_tick(scan_tick),
    .rtc_month(rtc_month), .rtc_mday(rtc_mday),
    .rtc_month_days(rtc_month_days), .rtc_wday(rtc_wday),
    .rtc_hour(rtc_hour), .rtc_min(rtc_min), .rtc_sec(rtc_sec));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int exp);
    checked++;
    if (n_pulse - mark != exp) begin
      n_mismatch++;
      $display("BAD %0t pulses %0d expected %0d", $time, n_pulse - mark, exp);
    end
    mark = n_pulse;
  endtask

  // Pulse must span exactly one scan period of 4 cycles
  always @(posedge pclk) begin
    pulse_q <= pulse_out;
    if (pulse_out === 1'b1) width++;
    if (pulse_out === 1'b1 && pulse_q !== 1'b1) n_pulse++;
    if (pulse_out === 1'b0 && pulse_q === 1'b1) begin
      check_word(32'(width), 32'h4);
      width = 0;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the slave
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_scans(input int n);
    repeat (n * 4) @(posedge pclk);
  endtask

  task automatic set_rtc(input logic [2:0] wd, input logic [4:0] md,
    input logic [4:0] mds, input logic [4:0] h, input logic [5:0] m,
    input logic [5:0] s);
    @(posedge pclk);
    ld <= 1'b1;
    ld_wday <= wd;
    ld_mday <= md;
    ld_mdays <= mds;
    ld_hour <= h;
    ld_min <= m;
    ld_sec <= s;
    @(posedge pclk);
    ld <= 1'b0;
    wait_scans(2);
  endtask

  // One second per step of 14 cycles, three or four scans inside each second
  task automatic step(input int n);
    repeat (n) begin
      @(posedge pclk);
      adv <= 1'b1;
      @(posedge pclk);
      adv <= 1'b0;
      wait_scans(3);
    end
  endtask

  task automatic set_hold(input logic v);
    @(posedge pclk);
    hold_in <= v;
    wait_scans(2);
  endtask

  task automatic t_regs;
    apb(1'b0, `PPT_OFF_CTRL, 32'h0);
    check_word(rd, 32'h0);
    check_word({31'h0, err}, 32'h0);
    apb(1'b0, `PPT_OFF_START_DATE, 32'h0);
    check_word(rd, 32'h00010101);
    apb(1'b0, `PPT_OFF_START_TIME, 32'h0);
    check_word(rd, 32'h0);
    apb(1'b0, `PPT_OFF_CYCLE, 32'h0);
    check_word(rd, 32'h0);
    // Reset start values match the reset clock, so one pulse has fired
    apb(1'b0, `PPT_OFF_STATUS, 32'h0);
    check_word(rd, 32'h00010000);
    apb(1'b0, 12'h014, 32'h0);
    check_word({31'h0, err}, 32'h1);
    check_word(rd, 32'h0);
  endtask

  task automatic t_clamp;
    apb(1'b1, `PPT_OFF_START_TIME, 32'h001e3f3f);
    apb(1'b0, `PPT_OFF_START_TIME, 32'h0);
    check_word(rd, 32'h00173b3b);
    apb(1'b1, `PPT_OFF_CYCLE, 32'h001e3f3f);
    apb(1'b0, `PPT_OFF_CYCLE, 32'h0);
    check_word(rd, 32'h00173b3b);
    apb(1'b1, `PPT_OFF_START_DATE, 32'h00020328);
    apb(1'b0, `PPT_OFF_START_DATE, 32'h0);
    check_word(rd, 32'h0002031f);
  endtask

  task automatic t_daily;
    set_rtc(3'h1, 5'h01, 5'h1f, 5'h0a, 6'h14, 6'h1c);
    apb(1'b1, `PPT_OFF_START_TIME, 32'h000a141e);
    apb(1'b1, `PPT_OFF_CTRL, 32'h2);
    mark = n_pulse;
    step(4);
    check_count(1);
    set_hold(1'b1);
    set_rtc(3'h1, 5'h01, 5'h1f, 5'h0a, 6'h14, 6'h1c);
    step(4);
    check_count(0);
    set_hold(1'b0);
  endtask

  task automatic t_weekly;
    set_rtc(3'h2, 5'h01, 5'h1f, 5'h01, 6'h02, 6'h01);
    apb(1'b1, `PPT_OFF_START_TIME, 32'h00010203);
    apb(1'b1, `PPT_OFF_START_DATE, 32'h00010301);
    apb(1'b1, `PPT_OFF_CTRL, 32'h1);
    mark = n_pulse;
    step(4);
    check_count(0);
    set_rtc(3'h3, 5'h01, 5'h1f, 5'h01, 6'h02, 6'h01);
    step(4);
    check_count(1);
  endtask

  task automatic t_monthly;
    set_rtc(3'h1, 5'h1e, 5'h1e, 5'h00, 6'h00, 6'h03);
    apb(1'b1, `PPT_OFF_START_DATE, 32'h00010128);
    apb(1'b1, `PPT_OFF_START_TIME, 32'h00000005);
    apb(1'b1, `PPT_OFF_CTRL, 32'h0);
    mark = n_pulse;
    step(4);
    check_count(1);
    set_rtc(3'h1, 5'h0f, 5'h1e, 5'h00, 6'h00, 6'h03);
    step(4);
    check_count(0);
    set_rtc(3'h1, 5'h1f, 5'h1f, 5'h00, 6'h00, 6'h03);
    step(4);
    check_count(1);
  endtask

  task automatic t_time_cycle;
    set_rtc(3'h1, 5'h01, 5'h1f, 5'h00, 6'h00, 6'h08);
    apb(1'b1, `PPT_OFF_START_TIME, 32'h0000000a);
    apb(1'b1, `PPT_OFF_CYCLE, 32'h00000003);
    apb(1'b1, `PPT_OFF_CTRL, 32'h3);
    mark = n_pulse;
    step(10);
    check_count(3);
    apb(1'b0, `PPT_OFF_STATUS, 32'h0);
    check_word(rd & 32'h3, 32'h2);
    set_hold(1'b1);
    mark = n_pulse;
    step(6);
    check_count(0);
    apb(1'b0, `PPT_OFF_STATUS, 32'h0);
    check_word(rd & 32'h3, 32'h0);
    set_hold(1'b0);
    apb(1'b1, `PPT_OFF_CTRL, 32'h5);
    set_rtc(3'h1, 5'h01, 5'h1f, 5'h00, 6'h00, 6'h08);
    step(4);
    check_count(0);
  endtask

  task automatic t_reset_cycle;
    apb(1'b1, `PPT_OFF_CYCLE, 32'h00000002);
    set_hold(1'b1);
    apb(1'b1, `PPT_OFF_CTRL, 32'h4);
    wait_scans(2);
    mark = n_pulse;
    set_hold(1'b0);
    check_count(1);
    step(5);
    check_count(2);
    set_hold(1'b1);
    step(4);
    check_count(0);
  endtask

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hold_in = 1'b0;
    ld = 1'b0;
    adv = 1'b0;
    ld_wday = 3'h1;
    ld_mday = 5'h01;
    ld_mdays = 5'h1f;
    ld_hour = 5'h00;
    ld_min = 6'h00;
    ld_sec = 6'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_clamp();
    t_daily();
    t_weekly();
    t_monthly();
    t_time_cycle();
    t_reset_cycle();
    summarize();
  end
endmodule

`default_nettype wire
